/* File: design/ohz_params.svh */
// offsets, field positions, masks and reset values of the output shutdown block
`ifndef OHZ_PARAMS_SVH
`define OHZ_PARAMS_SVH

`define OHZ_ADDR_W 12
`define OHZ_OFF_SW_DISABLE 12'h000
`define OHZ_OFF_SRC_ENABLE 12'h004
`define OHZ_OFF_FLAGS 12'h008
`define OHZ_OFF_IRQ_MASK 12'h00c
`define OHZ_OFF_ACTIVE_LVL2 12'h010
`define OHZ_OFF_LVL_STAT7 12'h014
`define OHZ_OFF_CTRL 12'h018

`define OHZ_SW_DISABLE_MASK 8'h5f
`define OHZ_SRC_ENABLE_MASK 16'h7b7d
`define OHZ_FLAGS_MASK 7'h7f

`define OHZ_SW_MOTOR_A 0
`define OHZ_SW_MOTOR_B 1
`define OHZ_SW_MOTOR_CH0 2
`define OHZ_SW_PWM_A 3
`define OHZ_SW_PWM_B 4
`define OHZ_SW_PWM_C 6

`define OHZ_EN_CMP_A 0
`define OHZ_EN_REQ4_A 2
`define OHZ_EN_REQ12_A 6
`define OHZ_EN_CMP_B 8
`define OHZ_EN_REQ0_B 9
`define OHZ_EN_REQ8_B 11
`define OHZ_EN_REQ12_B 14

`define OHZ_LVL2_POL12 0
`define OHZ_CTRL_PAIR_SEL 0

`define OHZ_RST_SW_DISABLE 8'h00
`define OHZ_RST_SRC_ENABLE 16'h0000
`define OHZ_RST_FLAGS 7'h00
`define OHZ_RST_IRQ_MASK 7'h00
`define OHZ_RST_ACTIVE_LVL2 1'b0
`define OHZ_RST_CTRL 1'b0

`endif

/* File: design/ohz_pkg.sv */
// types shared by the output shutdown block
package ohz_pkg;

    // one bit per group of timer outputs forced to high impedance
    typedef struct packed {
        logic pwm_c;
        logic pwm_b;
        logic pwm_a;
        logic motor_ch0;
        logic motor_b;
        logic motor_a;
    } ohz_hiz_s;

    // detection flags, same order as the flag register
    typedef struct packed {
        logic cmp;
        logic f12;
        logic f11;
        logic f10;
        logic f8;
        logic f4;
        logic f0;
    } ohz_flags_s;

endpackage

/* File: design/ohz_req_sync.sv */
// synchroniser and activation-edge detector for the request pins
module ohz_req_sync
    import ohz_pkg::*;
#(
    parameter int W = 6
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins and polarity
    input wire logic [W-1:0] pin_in,
    input wire logic [W-1:0] active_high,
    // synchronised level and activation pulse
    output logic [W-1:0] level,
    output logic [W-1:0] activate
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] act_prev_reg;
    logic [W-1:0] act;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    // a polarity change may itself look like an activation; software sets polarity first
    assign act = sync_reg ~^ active_high;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_prev_reg <= '0;
        end else begin
            act_prev_reg <= act;
        end
    end

    assign level = sync_reg;
    assign activate = act & ~act_prev_reg;

endmodule

/* File: design/ohz_top.sv */
// output shutdown block: request pins, flags, apb registers and hiz controls
//
// What this block does
// - six request pins 0,4,8,10,11,12, active low except selectable pin 12, each set their own detection flag.
// - extra polarity register and level status register serve request pin 12.
// - software bit 0 forces motor pair 3/4, or pair 6/7, to high impedance.
// - software bit 1 forces motor channels 6 and 7 to high impedance.
// - software bit 2 forces motor channel 0 to high impedance.
// - software bits 3, 4, 6 force pwm pairs 0/1, 2/3, 6/7 to high impedance.
// - source-enable bit 0 adds the comparator flag as a pair 3/4 source.
// - source-enable bits 2..6 add flags 4,8,10,11,12 as pair 3/4 sources.
// - source-enable bit 8 adds the comparator flag as a pair 6/7 source.
// - bits 9,11..14 add flags 0,8,10,11,12 for pair 6/7; bit 10 reserved.
`include "ohz_params.svh"

module ohz_top
    import ohz_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`OHZ_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request pins
    input wire logic hiz_request_in_0,
    input wire logic hiz_request_in_4,
    input wire logic hiz_request_in_8,
    input wire logic hiz_request_in_10,
    input wire logic hiz_request_in_11,
    input wire logic hiz_request_in_12,
    // on-chip comparator detection pulse
    input wire logic cmp_detect_in,
    // shutdown controls toward the timers, high means outputs at high impedance
    output ohz_hiz_s hiz_out,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] sw_disable_reg;
    logic [15:0] src_enable_reg;
    ohz_flags_s flags_reg;
    ohz_flags_s flags_next;
    logic [6:0] irq_mask_reg;
    logic active_level_second_reg;
    logic pair_sel_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    ohz_hiz_s hiz_reg;
    ohz_hiz_s hiz_next;
    logic irq_reg;

    logic [5:0] pin_vec;
    logic [5:0] pin_level;
    logic [5:0] pin_activate;
    logic [5:0] pin_pol;

    logic setup_phase;
    logic wr_strobe;
    logic [6:0] clr_bits;
    logic [6:0] set_bits;

    logic rd_setup;
    logic we_sw_disable;
    logic we_src_enable;
    logic we_flags;
    logic we_irq_mask;
    logic we_active_lvl2;
    logic we_ctrl;

    logic pair_a_sw;
    logic pair_a_cmp;
    logic pair_a_req;
    logic pair_b_sw;
    logic pair_b_cmp;
    logic pair_b_req;
    logic irq_next;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addr_mapped(input logic [`OHZ_ADDR_W-1:0] a);
        case (a)
            `OHZ_OFF_SW_DISABLE,
            `OHZ_OFF_SRC_ENABLE,
            `OHZ_OFF_FLAGS,
            `OHZ_OFF_IRQ_MASK,
            `OHZ_OFF_ACTIVE_LVL2,
            `OHZ_OFF_LVL_STAT7,
            `OHZ_OFF_CTRL: begin
                addr_mapped = 1'b1;
            end
            default: begin
                addr_mapped = 1'b0;
            end
        endcase
    endfunction

    // any enabled source among a group of flags
    function automatic logic any_enabled(input logic [4:0] flg, input logic [4:0] en);
        any_enabled = |(flg & en);
    endfunction

    // write strobe qualified by one register offset
    function automatic logic wr_hit(input logic wr, input logic [`OHZ_ADDR_W-1:0] a,
                                    input logic [`OHZ_ADDR_W-1:0] off);
        wr_hit = wr & (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // request pins

    assign pin_vec = {hiz_request_in_12, hiz_request_in_11, hiz_request_in_10,
                      hiz_request_in_8, hiz_request_in_4, hiz_request_in_0};

    // only pin 12 has a selectable polarity, the rest are fixed active low
    assign pin_pol = {active_level_second_reg, 5'h00};

    ohz_req_sync #(
        .W(6)
    ) u_req_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(pin_vec),
        .active_high(pin_pol),
        .level(pin_level),
        .activate(pin_activate)
    );

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    assign setup_phase = psel & ~penable;
    assign wr_strobe = psel & penable & pready_reg & pwrite & ~pslverr_reg;
    assign rd_setup = setup_phase & ~pwrite;

    // one decoded enable per register keeps the update blocks simple
    assign we_sw_disable = wr_hit(wr_strobe, paddr, `OHZ_OFF_SW_DISABLE);
    assign we_src_enable = wr_hit(wr_strobe, paddr, `OHZ_OFF_SRC_ENABLE);
    assign we_flags = wr_hit(wr_strobe, paddr, `OHZ_OFF_FLAGS);
    assign we_irq_mask = wr_hit(wr_strobe, paddr, `OHZ_OFF_IRQ_MASK);
    assign we_active_lvl2 = wr_hit(wr_strobe, paddr, `OHZ_OFF_ACTIVE_LVL2);
    assign we_ctrl = wr_hit(wr_strobe, paddr, `OHZ_OFF_CTRL);

    // no wait states: every access is answered in its first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup_phase;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= setup_phase & ~addr_mapped(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                `OHZ_OFF_SW_DISABLE: begin
                    prdata_reg <= {24'h00_0000, sw_disable_reg};
                end
                `OHZ_OFF_SRC_ENABLE: begin
                    prdata_reg <= {16'h0000, src_enable_reg};
                end
                `OHZ_OFF_FLAGS: begin
                    prdata_reg <= {25'h000_0000, flags_reg};
                end
                `OHZ_OFF_IRQ_MASK: begin
                    prdata_reg <= {25'h000_0000, irq_mask_reg};
                end
                `OHZ_OFF_ACTIVE_LVL2: begin
                    prdata_reg <= {31'h0000_0000, active_level_second_reg};
                end
                `OHZ_OFF_LVL_STAT7: begin
                    // level of pin 12 and its flag
                    prdata_reg <= {30'h0000_0000, flags_reg.f12, pin_level[5]};
                end
                `OHZ_OFF_CTRL: begin
                    prdata_reg <= {31'h0000_0000, pair_sel_reg};
                end
                default: begin
                    prdata_reg <= 32'h0000_0000;
                end
            endcase
        end else begin
            // cleared after the access cycle so an idle bus reads zero
            prdata_reg <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software writable registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_disable_reg <= `OHZ_RST_SW_DISABLE;
        end else if (we_sw_disable) begin
            sw_disable_reg <= pwdata[7:0] & `OHZ_SW_DISABLE_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_enable_reg <= `OHZ_RST_SRC_ENABLE;
        end else if (we_src_enable) begin
            src_enable_reg <= pwdata[15:0] & `OHZ_SRC_ENABLE_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= `OHZ_RST_IRQ_MASK;
        end else if (we_irq_mask) begin
            irq_mask_reg <= pwdata[6:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_level_second_reg <= `OHZ_RST_ACTIVE_LVL2;
        end else if (we_active_lvl2) begin
            active_level_second_reg <= pwdata[`OHZ_LVL2_POL12];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_sel_reg <= `OHZ_RST_CTRL;
        end else if (we_ctrl) begin
            pair_sel_reg <= pwdata[`OHZ_CTRL_PAIR_SEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // detection flags, sticky, write one to clear

    assign clr_bits = we_flags ? (pwdata[6:0] & `OHZ_FLAGS_MASK) : 7'h00;
    assign set_bits = {cmp_detect_in, pin_activate};

    // a new activation in the clearing cycle is kept: set wins
    always_comb begin
        flags_next = ohz_flags_s'((flags_reg & ~clr_bits) | set_bits);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= ohz_flags_s'(`OHZ_RST_FLAGS);
        end else begin
            flags_reg <= flags_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // high impedance decisions

    // pair terms kept apart so each source traces to its own enable bit
    assign pair_a_sw = sw_disable_reg[`OHZ_SW_MOTOR_A] & ~pair_sel_reg;
    assign pair_a_cmp = flags_reg.cmp & src_enable_reg[`OHZ_EN_CMP_A];
    assign pair_a_req = any_enabled({flags_reg.f12, flags_reg.f11, flags_reg.f10,
                                     flags_reg.f8, flags_reg.f4},
                                    src_enable_reg[`OHZ_EN_REQ12_A:`OHZ_EN_REQ4_A]);
    assign pair_b_sw = sw_disable_reg[`OHZ_SW_MOTOR_B]
                       | (sw_disable_reg[`OHZ_SW_MOTOR_A] & pair_sel_reg);
    assign pair_b_cmp = flags_reg.cmp & src_enable_reg[`OHZ_EN_CMP_B];
    assign pair_b_req = any_enabled({flags_reg.f12, flags_reg.f11, flags_reg.f10,
                                     flags_reg.f8, flags_reg.f0},
                                    {src_enable_reg[`OHZ_EN_REQ12_B:`OHZ_EN_REQ8_B],
                                     src_enable_reg[`OHZ_EN_REQ0_B]});

    always_comb begin
        hiz_next = '0;
        // pair 3/4: software bit unless steered to pair 6/7
        hiz_next.motor_a = pair_a_sw | pair_a_cmp | pair_a_req;
        // pair 6/7: its own bit, the steered bit and its sources
        hiz_next.motor_b = pair_b_sw | pair_b_cmp | pair_b_req;
        hiz_next.motor_ch0 = sw_disable_reg[`OHZ_SW_MOTOR_CH0];
        hiz_next.pwm_a = sw_disable_reg[`OHZ_SW_PWM_A];
        hiz_next.pwm_b = sw_disable_reg[`OHZ_SW_PWM_B];
        hiz_next.pwm_c = sw_disable_reg[`OHZ_SW_PWM_C];
    end

    // registered so the timer side sees glitch-free controls, one cycle late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hiz_reg <= '0;
        end else begin
            hiz_reg <= hiz_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt

    // one cycle of lag buys an output straight from a flop
    assign irq_next = |(flags_reg & irq_mask_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign hiz_out = hiz_reg;
    assign irq = irq_reg;

endmodule

/* File: test/ohz_top_asserts.sv */
// assertion checker for the output shutdown block
`include "ohz_params.svh"
module ohz_chk
    import ohz_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`OHZ_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // shutdown controls
    input wire ohz_hiz_s hiz_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_any, wr_sw, rd_acc;
    logic [3:0] sw_side;
    assign wr_any = psel && penable && pwrite;
    assign wr_sw = wr_any && pready && paddr == `OHZ_OFF_SW_DISABLE;
    assign rd_acc = pready && !pwrite;
    assign sw_side = {hiz_out.pwm_c, hiz_out.pwm_b, hiz_out.pwm_a, hiz_out.motor_ch0};
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence sw_wr_s;
        wr_sw;
    endsequence
    ////////////////////////////////////////
    ready_after_setup_a: assert property (setup_s |=> pready)
        else $error("setup not answered");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    unmapped_err_a: assert property (pready && paddr[1:0] == 2'h0 |->
        pslverr == (paddr > `OHZ_OFF_CTRL)) else $error("wrong error response");
    idle_rdata_zero_a: assert property (!psel |-> prdata == 32'h0)
        else $error("read data not zero when idle");
    sw_rsvd_zero_a: assert property (rd_acc && paddr == 12'h000 |->
        (prdata & 32'hffffffa0) == 32'h0) else $error("reserved bits set");
    en_rsvd_zero_a: assert property (rd_acc && paddr == 12'h004 |->
        (prdata & 32'hffff8482) == 32'h0) else $error("reserved bits set");
    sw_bits_a: assert property (sw_wr_s |-> ##2 hiz_out.motor_ch0 == $past(pwdata[2], 2))
        else $error("software bit not applied");
    sw_hold_a: assert property (!$stable(sw_side) |-> $past(wr_sw, 2))
        else $error("software outputs moved alone");
    pair_release_a: assert property ($fell(hiz_out.motor_a) || $fell(hiz_out.motor_b) |->
        $past(wr_any, 2)) else $error("pair released without a write");
endmodule
////////////////////////////////////////
bind ohz_top ohz_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hiz_out(hiz_out));

/* File: test/ohz_fault_src.sv */
// far-side model: fault request pins and comparator pulse
module ohz_fault_src (
    // requests from the bench, bit 6 is the comparator
    input wire logic [6:0] fault_cmd,
    // lines toward the block
    output logic [5:0] req_pin_n,
    output logic cmp_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    // fault lines idle high and are pulled low only while reporting
    assign req_pin_n = ~fault_cmd[5:0];
    assign cmp_pulse = fault_cmd[6];
endmodule

/* File: test/tb_output_hiz_shutdown_control.sv */
// self-checking bench for the output shutdown block
`include "ohz_params.svh"
module tb_output_hiz_shutdown_control
    import ohz_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [`OHZ_ADDR_W-1:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv;
    logic pready, pslverr, irq, cmp_pulse, err;
    logic [5:0] pin_n;
    logic [6:0] fault_cmd = 0;
    ohz_hiz_s hiz_out;
    int n_mismatch = 0, n_compared = 0;
    int sw, en, ctrl, mask, flags;
    int offs[$] = '{0, 4, 8, 12, 16, 20, 24};
    always #20 pclk = ~pclk;
    ohz_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hiz_request_in_0(pin_n[0]), .hiz_request_in_4(pin_n[1]),
        .hiz_request_in_8(pin_n[2]), .hiz_request_in_10(pin_n[3]),
        .hiz_request_in_11(pin_n[4]), .hiz_request_in_12(pin_n[5]),
        .cmp_detect_in(cmp_pulse), .hiz_out(hiz_out), .irq(irq));
    ohz_fault_src far_u (.fault_cmd(fault_cmd), .req_pin_n(pin_n), .cmp_pulse(cmp_pulse));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one transfer; waits on pready, never on a fixed count
    task automatic apb(input logic w, input int a, input int d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 12'(a);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [5:0] exp_hiz();
        logic a, b;
        a = sw[0] & !ctrl[0] | en[0] & flags[6] | |(en[6:2] & flags[5:1]);
        b = sw[1] | sw[0] & ctrl[0] | en[8] & flags[6] | en[9] & flags[0]
            | |(en[14:11] & flags[5:2]);
        return {sw[6], sw[4], sw[3], sw[2], b, a};
    endfunction
    // outputs are registered, so allow the landing edge plus one
    task automatic look();
        repeat (2) @(posedge pclk);
        chk({26'h0, hiz_out}, {26'h0, exp_hiz()});
        chk({31'h0, irq}, {31'h0, (flags & mask) != 0});
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        void'($urandom(38));
        {sw, en, ctrl, mask, flags} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (offs[k]) begin
            apb(0, offs[k], 0);
            // idle pin 12 sits high, so its level status reads one
            chk(rdv, offs[k] == `OHZ_OFF_LVL_STAT7 ? 1 : 0);
        end
        apb(0, 32'h01c, 0);
        chk({rdv[30:0], err}, 1);
        $display("reset and map test done");
        for (int i = 0; i < 8; i++) begin
            sw = $urandom;
            ctrl = $urandom & 1;
            apb(1, `OHZ_OFF_CTRL, ctrl);
            apb(1, `OHZ_OFF_SW_DISABLE, sw);
            sw &= 32'h5f;
            look();
            apb(0, `OHZ_OFF_SW_DISABLE, 0);
            chk(rdv, sw);
        end
        apb(1, `OHZ_OFF_SW_DISABLE, 0);
        sw = 0;
        $display("software disable test done");
        for (int i = 0; i < 7; i++) begin
            en = (i % 3) ? $urandom & 32'h7b7d : 32'h7b7d;
            mask = (i % 2) ? 0 : 32'h7f;
            apb(1, `OHZ_OFF_SRC_ENABLE, en);
            apb(1, `OHZ_OFF_IRQ_MASK, mask);
            apb(0, `OHZ_OFF_SRC_ENABLE, 0);
            chk(rdv, en);
            fault_cmd <= 7'(1 << i);
            repeat (6) @(posedge pclk);
            flags = 1 << i;
            if (i == 6) fault_cmd <= 7'h0;
            look();
            apb(0, `OHZ_OFF_LVL_STAT7, 0);
            chk(rdv, i == 5 ? 2 : 1);
            apb(0, `OHZ_OFF_FLAGS, 0);
            chk(rdv, flags);
            // pin still held: a cleared flag must not come back
            apb(1, `OHZ_OFF_FLAGS, flags);
            flags = 0;
            look();
            fault_cmd <= 7'h0;
        end
        $display("request source test done");
        apb(1, `OHZ_OFF_ACTIVE_LVL2, 1);
        repeat (4) @(posedge pclk);
        flags = 32'h20;
        look();
        apb(1, `OHZ_OFF_ACTIVE_LVL2, 0);
        apb(1, `OHZ_OFF_FLAGS, flags);
        flags = 0;
        look();
        $display("polarity test done");
        end_of_test();
    end
endmodule
